// *** inc/ufx_defines.svh ***
// constants for the usart frame transmitter
//------------------------------------------------------------------
// Operation
// RL1: all thirty formats: 5..9 data bits, none/even/odd parity, 1 or 2 stops
// RL2: data bits go out least significant first, up to nine
// RL3: parity bit sits right after the last data bit, before the stop bits
// RL4: next frame may follow at once, otherwise the line idles high
// RL5: start bit is always low
// RL6: every stop bit is always high
// RL7: one frame format register shared by both directions
// RL8: char_size_field, parity_mode_field, stop_bit_select choose the format
// RL9: receiver checks only the first stop bit for frame errors
// RL10: parity is xor of data bits, inverted for odd
// RL11: tx_enable_bit hands serial_out_pin to the transmitter
// RL12: synchronous mode clocks transmission from transfer_clock_pin
// RL13: writing data_buffer_reg loads the buffer and starts sending
// RL14: buffer moves to shifter when idle or right after last stop bit
// RL15: shifter sends a whole frame at the selected bit rate
// RL16: unused upper data bits are ignored for short characters
// RL17: host writes tx_ninth_bit before the low byte
// RL18: host waits for an empty buffer before writing data
// RL19: host sets rate, mode and format before sending
// RL20: host keeps transfers quiet while changing rate or format
// RL21: host clears tx_complete_flag before each data write
// RL22: tx_buffer_empty_flag high while the buffer is empty
// RL23: tx_complete_flag set when frame done and buffer empty
// RL24: disabling waits until buffer and shifter are empty, then releases pin
// RL25: bit clock is baud output divided by 2, 8 or 16
// RL26: no parity slot when parity is off
// RL27: enabled and idle transmitter drives the line high
//------------------------------------------------------------------
`ifndef UFX_DEFINES_SVH
`define UFX_DEFINES_SVH
`define UFX_ADDR_DATA    3'h0
`define UFX_ADDR_STATUS  3'h1
`define UFX_ADDR_CTRL_B  3'h2
`define UFX_ADDR_CTRL_C  3'h3
`define UFX_ADDR_BAUD_L  3'h4
`define UFX_ADDR_BAUD_H  3'h5
// status register bits
`define UFX_ST_TXC       6
`define UFX_ST_UDRE      5
`define UFX_ST_U2X       1
// control b bits
`define UFX_CB_TXEN      3
`define UFX_CB_UCSZ2     2
`define UFX_CB_TXB8      0
// control c bits
`define UFX_CC_MSEL      6
`define UFX_CC_PM_HI     5
`define UFX_CC_PM_LO     4
`define UFX_CC_SBS       3
`define UFX_CC_CS_HI     2
`define UFX_CC_CS_LO     1
`define UFX_CC_CPOL      0
// reset values
`define UFX_RST_CTRL_C   8'h06
`define UFX_RST_STATUS   8'h20
// bit clock divider tops, nine-bit size code, odd parity code
`define UFX_DIV_NORM     4'hf
`define UFX_DIV_DBL      4'h7
`define UFX_DIV_SYNC     4'h1
`define UFX_CS_NINE      3'h7
`define UFX_PM_ODD       2'h3
`endif

// *** inc/ufx_pkg.sv ***
// types for the usart frame transmitter
package ufx_pkg;
  typedef enum logic [2:0] {
    UFX_IDLE,
    UFX_START,
    UFX_DATA,
    UFX_PARITY,
    UFX_STOP1,
    UFX_STOP2
  } ufx_state_type;

  typedef struct packed {
    logic [1:0] parity_mode_field;
    logic       stop_bit_select;
    logic [2:0] char_size_field;
  } ufx_format_type;
endpackage

// *** design/ufx_transmitter.sv ***
// usart transmit path with frame format and register port
`timescale 1ns/1ps
`include "ufx_defines.svh"
module ufx_transmitter
  import ufx_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       rst_b,
  input  wire logic [2:0] addr,
  input  wire logic [7:0] wdata,
  input  wire logic       wr,
  input  wire logic       rd,
  output logic      [7:0] rdata,
  input  wire logic       xck_in,
  output logic            xck_out,
  output logic            xck_oe,
  input  wire logic       xck_dir_master,
  output logic            serial_out_pin,
  output logic            serial_out_oe
);

  //------------------------------------------------------------------
  // helpers
  //------------------------------------------------------------------
  // data bit count from char_size_field; 4..7 beyond 3 other than 7 read as 8
  function automatic logic [3:0] data_bits(input logic [2:0] cs);  // RL1
    case (cs)
      3'h0:    data_bits = 4'h5;
      3'h1:    data_bits = 4'h6;
      3'h2:    data_bits = 4'h7;
      3'h7:    data_bits = 4'h9;
      default: data_bits = 4'h8;
    endcase
  endfunction

  //------------------------------------------------------------------
  // registers
  //------------------------------------------------------------------
  logic [7:0]     buf_r, buf_nxt;
  logic           buf_b8_r, buf_b8_nxt;
  logic           udre_r, udre_nxt;
  logic           txc_r, txc_nxt;
  logic           u2x_r, u2x_nxt;
  logic           txen_r, txen_nxt;
  logic           txb8_r, txb8_nxt;
  logic           msel_r, msel_nxt;
  logic           cpol_r, cpol_nxt;
  // one format register; read by the transmit path and by the register read port
  ufx_format_type fmt_r, fmt_nxt;  // RL7
  logic [11:0]    ubrr_r, ubrr_nxt;
  logic [7:0]     rdata_nxt;
  logic [11:0]    bcnt_r, bcnt_nxt;
  logic [3:0]     pcnt_r, pcnt_nxt;
  logic           xs1_r, xs2_r, xs3_r;
  logic           xck_out_nxt;
  ufx_state_type  st_r, st_nxt;
  logic [8:0]     sh_r, sh_nxt;
  logic [3:0]     bit_r, bit_nxt;
  logic           par_r, par_nxt;
  logic           so_nxt, soe_nxt;

  logic [3:0]     div_top;
  logic           baud_tick, bit_en, last_stop;

  // register port: writes and reads
  always_comb begin
    buf_nxt    = buf_r;
    buf_b8_nxt = buf_b8_r;
    txc_nxt    = txc_r;
    u2x_nxt    = u2x_r;
    txen_nxt   = txen_r;
    txb8_nxt   = txb8_r;
    msel_nxt   = msel_r;
    cpol_nxt   = cpol_r;
    fmt_nxt    = fmt_r;
    ubrr_nxt   = ubrr_r;
    rdata_nxt  = 8'h00;
    if (wr) begin
      unique case (addr)
        `UFX_ADDR_DATA: begin
          buf_nxt    = wdata;    // RL13
          buf_b8_nxt = txb8_r;   // ninth bit captured with the low byte
        end
        `UFX_ADDR_STATUS: begin
          u2x_nxt = wdata[`UFX_ST_U2X];
          if (wdata[`UFX_ST_TXC])
            txc_nxt = 1'b0;      // write one clears
        end
        `UFX_ADDR_CTRL_B: begin
          txen_nxt             = wdata[`UFX_CB_TXEN];
          fmt_nxt.char_size_field[2] = wdata[`UFX_CB_UCSZ2];  // RL8
          txb8_nxt             = wdata[`UFX_CB_TXB8];
        end
        `UFX_ADDR_CTRL_C: begin
          msel_nxt                     = wdata[`UFX_CC_MSEL];
          fmt_nxt.parity_mode_field    = wdata[`UFX_CC_PM_HI:`UFX_CC_PM_LO];  // RL8
          fmt_nxt.stop_bit_select      = wdata[`UFX_CC_SBS];
          fmt_nxt.char_size_field[1:0] = wdata[`UFX_CC_CS_HI:`UFX_CC_CS_LO];
          cpol_nxt                     = wdata[`UFX_CC_CPOL];
        end
        `UFX_ADDR_BAUD_L: ubrr_nxt[7:0]  = wdata;
        `UFX_ADDR_BAUD_H: ubrr_nxt[11:8] = wdata[3:0];
        default: ;
      endcase
    end
    // a hardware set of the complete flag beats a same-cycle clear; a byte
    // that was waiting at the end of the stop keeps the flag low, since the
    // next frame starts at once
    if (last_stop && udre_r)
      txc_nxt = 1'b1;            // RL23
    if (rd) begin
      unique case (addr)
        `UFX_ADDR_STATUS: rdata_nxt = {1'b0, txc_r, udre_r, 3'h0, u2x_r, 1'b0};
        `UFX_ADDR_CTRL_B: rdata_nxt = {4'h0, txen_r, fmt_r.char_size_field[2],
                                       1'b0, txb8_r};
        `UFX_ADDR_CTRL_C: rdata_nxt = {1'b0, msel_r, fmt_r.parity_mode_field,
                                       fmt_r.stop_bit_select,
                                       fmt_r.char_size_field[1:0], cpol_r};
        `UFX_ADDR_BAUD_L: rdata_nxt = ubrr_r[7:0];
        `UFX_ADDR_BAUD_H: rdata_nxt = {4'h0, ubrr_r[11:8]};
        default:          rdata_nxt = 8'h00;
      endcase
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      buf_r    <= 8'h00;
      buf_b8_r <= 1'b0;
      txc_r    <= 1'b0;
      u2x_r    <= 1'b0;
      txen_r   <= 1'b0;
      txb8_r   <= 1'b0;
      msel_r   <= 1'b0;
      cpol_r   <= 1'b0;
      fmt_r    <= ufx_format_type'(6'(`UFX_RST_CTRL_C >> 1));
      ubrr_r   <= 12'h000;
      rdata    <= 8'h00;
    end else begin
      buf_r    <= buf_nxt;
      buf_b8_r <= buf_b8_nxt;
      txc_r    <= txc_nxt;
      u2x_r    <= u2x_nxt;
      txen_r   <= txen_nxt;
      txb8_r   <= txb8_nxt;
      msel_r   <= msel_nxt;
      cpol_r   <= cpol_nxt;
      fmt_r    <= fmt_nxt;
      ubrr_r   <= ubrr_nxt;
      rdata    <= rdata_nxt;
    end
  end

  //------------------------------------------------------------------
  // bit clock: baud down-counter, then 2/8/16 prescale or external clock
  //------------------------------------------------------------------
  // sync master divides by 2, async by 8 or 16
  assign div_top   = msel_r ? `UFX_DIV_SYNC : (u2x_r ? `UFX_DIV_DBL : `UFX_DIV_NORM);  // RL25
  assign baud_tick = (bcnt_r == 12'h000);

  // external clock: change edge set by polarity, after two-flop sync
  always_comb begin
    bcnt_nxt    = baud_tick ? ubrr_r : bcnt_r - 12'h001;
    if (wr && addr == `UFX_ADDR_BAUD_L)
      bcnt_nxt = {ubrr_r[11:8], wdata};   // reload on low byte write
    pcnt_nxt    = pcnt_r;
    xck_out_nxt = xck_out;
    if (baud_tick) begin
      pcnt_nxt = (pcnt_r >= div_top) ? 4'h0 : pcnt_r + 4'h1;
      if (msel_r)
        xck_out_nxt = ~xck_out;
    end
    if (!msel_r)
      xck_out_nxt = 1'b0;
    if (msel_r && !xck_dir_master)                // RL12
      bit_en = cpol_r ? (xs3_r & ~xs2_r) : (~xs3_r & xs2_r);
    else if (msel_r)
      // change data on the clock edge chosen by polarity; taking the phase from
      // the prescaler could lock onto the sampling edge and never send
      bit_en = baud_tick && (xck_out == cpol_r);
    else
      bit_en = baud_tick && pcnt_r == div_top;   // RL15
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      bcnt_r  <= 12'h000;
      pcnt_r  <= 4'h0;
      xck_out <= 1'b0;
      xck_oe  <= 1'b0;
      xs1_r   <= 1'b0;
      xs2_r   <= 1'b0;
      xs3_r   <= 1'b0;
    end else begin
      bcnt_r  <= bcnt_nxt;
      pcnt_r  <= pcnt_nxt;
      xck_out <= xck_out_nxt;
      xck_oe  <= msel_r & xck_dir_master;
      xs1_r   <= xck_in;
      xs2_r   <= xs1_r;
      xs3_r   <= xs2_r;
    end
  end

  //------------------------------------------------------------------
  // frame shifter
  //------------------------------------------------------------------
  // load rule: buffer full and shifter idle, or at the end of the last stop
  always_comb begin
    st_nxt   = st_r;
    sh_nxt   = sh_r;
    bit_nxt  = bit_r;
    par_nxt  = par_r;
    udre_nxt = udre_r;
    so_nxt   = serial_out_pin;
    last_stop = 1'b0;
    if (bit_en) begin
      unique case (st_r)
        UFX_IDLE: begin
          so_nxt = 1'b1;                          // RL27 RL4
          // a byte left behind by a disable still goes out while the pin is held
          if (!udre_r && (txen_r || serial_out_oe)) begin  // RL14 RL24
            // upper bits beyond the size are masked off
            sh_nxt   = {buf_b8_r, buf_r} & ((9'h001 << data_bits(fmt_r.char_size_field))
                                            - 9'h001);  // RL16
            par_nxt  = fmt_r.parity_mode_field == `UFX_PM_ODD;  // RL10
            udre_nxt = 1'b1;
            so_nxt   = 1'b0;                      // RL5
            st_nxt   = UFX_START;
          end
        end
        UFX_START, UFX_DATA: begin
          so_nxt  = sh_r[0];                      // RL2
          par_nxt = par_r ^ sh_r[0];              // RL10
          sh_nxt  = {1'b0, sh_r[8:1]};
          bit_nxt = (st_r == UFX_START) ? 4'h1 : bit_r + 4'h1;
          st_nxt  = UFX_DATA;
          if (st_r == UFX_DATA && bit_r == data_bits(fmt_r.char_size_field)) begin
            so_nxt  = fmt_r.parity_mode_field[1] ? par_r : 1'b1;  // RL3 RL26
            st_nxt  = fmt_r.parity_mode_field[1] ? UFX_PARITY : UFX_STOP1;
            bit_nxt = 4'h0;
            sh_nxt  = sh_r;
            par_nxt = par_r;
          end
        end
        UFX_PARITY: begin
          so_nxt = 1'b1;                          // RL6
          st_nxt = UFX_STOP1;
        end
        UFX_STOP1: begin
          so_nxt = 1'b1;                          // RL6
          if (fmt_r.stop_bit_select)
            st_nxt = UFX_STOP2;
          else
            last_stop = 1'b1;
        end
        // the far end checks only the first stop; the second is line time
        UFX_STOP2: begin                          // RL9
          so_nxt    = 1'b1;                       // RL6
          last_stop = 1'b1;
        end
      endcase
      if (last_stop) begin
        st_nxt = UFX_IDLE;
        if (!udre_r) begin                        // RL14 back to back
          sh_nxt   = {buf_b8_r, buf_r} & ((9'h001 << data_bits(fmt_r.char_size_field))
                                          - 9'h001);
          par_nxt  = fmt_r.parity_mode_field == `UFX_PM_ODD;
          udre_nxt = 1'b1;
          so_nxt   = 1'b0;
          st_nxt   = UFX_START;
        end
      end
    end
    // a write beats a same-cycle load: the new byte is still waiting
    if (wr && addr == `UFX_ADDR_DATA)
      udre_nxt = 1'b0;                            // RL22
    // pin is held while enabled or while data remain to send; a byte written
    // to a disabled, released transmitter waits and does not grab the pin
    soe_nxt = txen_r || st_r != UFX_IDLE || (!udre_r && serial_out_oe);  // RL11 RL24
    if (!soe_nxt)
      so_nxt = 1'b1;
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      st_r           <= UFX_IDLE;
      sh_r           <= 9'h000;
      bit_r          <= 4'h0;
      par_r          <= 1'b0;
      udre_r         <= 1'b1;
      serial_out_pin <= 1'b1;
      serial_out_oe  <= 1'b0;
    end else begin
      st_r           <= st_nxt;
      sh_r           <= sh_nxt;
      bit_r          <= bit_nxt;
      par_r          <= par_nxt;
      udre_r         <= udre_nxt;
      serial_out_pin <= so_nxt;
      serial_out_oe  <= soe_nxt;
    end
  end

endmodule

// *** dv/ufx_transmitter_checker.sv ***
// port checker for the usart frame transmitter
`timescale 1ns/1ps
module ufx_transmitter_checker (
  input wire logic       clk,
  input wire logic       rst_b,
  input wire logic [2:0] addr,
  input wire logic [7:0] wdata,
  input wire logic       wr,
  input wire logic       xck_dir_master,
  input wire logic       xck_oe,
  input wire logic       xck_out,
  input wire logic       serial_out_pin,
  input wire logic       serial_out_oe
);
  // ---------------------------------------------
  // line and clock pin checks
  // ---------------------------------------------
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);
  sequence s_en_wr; wr && addr == 3'h2 && wdata[3]; endsequence
  sequence s_sync_wr; wr && addr == 3'h3 && wdata[6]; endsequence
  sequence s_async_wr; wr && addr == 3'h3 && !wdata[6]; endsequence
  // every bit lasts two clocks at least, even at the fastest sync rate
  property p_start_low; serial_out_oe && $fell(serial_out_pin) |=> !serial_out_pin; endproperty
  a_start_low: assert property (p_start_low) else $error("low bit too short");
  property p_bit_hold; $changed(serial_out_pin) |=> $stable(serial_out_pin); endproperty
  a_bit_hold: assert property (p_bit_hold) else $error("bit too short");
  property p_en_take; s_en_wr |-> ##[1:3] serial_out_oe; endproperty
  a_en_take: assert property (p_en_take) else $error("pin not taken");
  property p_off_high; !serial_out_oe |-> serial_out_pin; endproperty
  a_off_high: assert property (p_off_high) else $error("line low while released");
  // release only lands on an idle line, never inside a frame
  property p_drop_idle; $fell(serial_out_oe) |-> serial_out_pin && $past(serial_out_pin); endproperty
  a_drop_idle: assert property (p_drop_idle) else $error("pin released mid frame");
  property p_sync_on; s_sync_wr ##1 xck_dir_master [*2] |-> xck_oe; endproperty
  a_sync_on: assert property (p_sync_on) else $error("clock pin not driven");
  property p_async_off; s_async_wr |-> ##2 !xck_oe; endproperty
  a_async_off: assert property (p_async_off) else $error("clock pin driven async");
  property p_slave_off; !xck_dir_master [*2] |-> !xck_oe; endproperty
  a_slave_off: assert property (p_slave_off) else $error("clock pin driven as slave");
  // master clock edge and data change share one register edge
  property p_sync_edge; xck_oe && $changed(serial_out_pin) |-> $changed(xck_out); endproperty
  a_sync_edge: assert property (p_sync_edge) else $error("data moved off clock edge");
endmodule
bind ufx_transmitter ufx_transmitter_checker u_chk (.clk(clk), .rst_b(rst_b), .addr(addr),
  .wdata(wdata), .wr(wr), .xck_dir_master(xck_dir_master), .xck_oe(xck_oe),
  .xck_out(xck_out),
  .serial_out_pin(serial_out_pin), .serial_out_oe(serial_out_oe));

// *** dv/ufx_line_receiver.sv ***
// remote serial receiver model on the transmit line
`timescale 1ns/1ps
module ufx_line_receiver (
  input  wire logic        clk,
  input  wire logic        line,
  input  wire logic [3:0]  frame_bits,
  input  wire logic [7:0]  bit_clocks,
  output logic      [12:0] frame,
  output logic             start_bit,
  output int               frames
);
  // samples mid bit from the falling start edge; the second stop is kept
  // too so the bench can see it, although a real receiver ignores it
  initial begin
    frames = 0;
    forever begin
      @(negedge line);
      repeat (bit_clocks / 2) @(posedge clk);
      start_bit = line;
      frame = 13'h0;
      for (int i = 0; i < frame_bits; i++) begin
        repeat (bit_clocks) @(posedge clk);
        frame[i] = line;
      end
      frames++;
    end
  end
endmodule

// *** dv/test_usart_frame_transmitter.sv ***
// self-checking testbench for the usart frame transmitter
`timescale 1ns/1ps
module test_usart_frame_transmitter;
  logic        clk, rst_b, wr, rd, xck_dir_master, xck_oe;
  logic        serial_out_pin, serial_out_oe, rx_start, msel, u2x, cpol, xck_run;
  logic        xck_in = 1'b0;
  logic [1:0]  xck_cnt = 2'h0;
  logic [2:0]  addr;
  logic [7:0]  wdata, rdata, bc;
  logic [12:0] rx_frame;
  logic [3:0]  fb;
  int          frames, errors, comparisons;

  ufx_transmitter DUT (.clk(clk), .rst_b(rst_b), .addr(addr), .wdata(wdata), .wr(wr),
    .rd(rd), .rdata(rdata), .xck_in(xck_in), .xck_out(), .xck_oe(xck_oe),
    .xck_dir_master(xck_dir_master), .serial_out_pin(serial_out_pin),
    .serial_out_oe(serial_out_oe));
  ufx_line_receiver u_rx (.clk(clk), .line(serial_out_pin), .frame_bits(fb),
    .bit_clocks(bc), .frame(rx_frame), .start_bit(rx_start), .frames(frames));

  always #50 clk = ~clk;
  // remote clock master for sync slave runs: one level per four clocks
  always @(posedge clk) begin
    xck_cnt <= xck_cnt + 2'h1;
    if (xck_run && xck_cnt == 2'h3) xck_in <= ~xck_in;
  end
  // ---------------------------------------------
  // bus and compare helpers
  // ---------------------------------------------
  task automatic wreg(input logic [2:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  // read data stand only in the cycle after the strobe
  task automatic rreg(input logic [2:0] a, output logic [7:0] d);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 d = rdata;
  endtask
  task automatic chk(input string n, input logic [12:0] e, input logic [12:0] g);
    comparisons++;
    if (g !== e) begin
      errors++;
      $display("Error %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic wait_frame(input int n);
    for (int t = 0; t < 4000 && frames < n; t++) @(posedge clk);
    chk("frames", 13'(n), 13'(frames));
  endtask
  // ---------------------------------------------
  // scenarios
  // ---------------------------------------------
  // expected frame built bit by bit; off drops the enable right after the data
  task automatic send(input logic [8:0] d, input logic [2:0] cs, input logic [1:0] pm,
                      input logic sb, input logic off);
    logic [12:0] e;
    int n;
    logic [7:0] s;
    n = (cs == 3'h7) ? 9 : int'(cs) + 5;
    e = 13'h0;
    for (int k = 0; k < n; k++) e[k] = d[k];
    if (pm[1]) begin
      e[n] = (^e) ^ pm[0];
      n++;
    end
    e[n] = 1'b1;
    e[n + 1] = sb;
    fb = 4'(n + 1 + int'(sb));
    wreg(3'h3, {1'b0, msel, pm, sb, cs[1:0], cpol});
    wreg(3'h2, {4'h0, 1'b1, cs[2], 1'b0, d[8]});
    wreg(3'h1, {6'h10, u2x, 1'b0});
    n = frames;
    wreg(3'h0, d[7:0]);
    if (off) wreg(3'h2, 8'h00);
    wait_frame(n + 1);
    chk("frame", e, rx_frame);
    chk("start", 13'h0, {12'h0, rx_start});
    // format and rate may only change once the line has gone quiet
    s = 8'h00;
    for (int t = 0; t < 400 && !s[6]; t++) rreg(3'h1, s);
    chk("complete", 13'h1, {12'h0, s[6]});
  endtask
  task automatic t_reset;
    logic [7:0] s;
    rreg(3'h1, s);
    chk("status", 13'h20, {5'h0, s});
    wreg(3'h7, 8'hff);
    rreg(3'h7, s);
    chk("unmapped", 13'h0, {5'h0, s});
    rreg(3'h3, s);
    chk("format", 13'h6, {5'h0, s});
    chk("released", 13'h1, {11'h0, serial_out_oe, serial_out_pin});
  endtask
  task automatic t_formats;
    for (int i = 0; i < 30; i++) begin
      send(9'(i * 83 + 346), (i % 5 == 4) ? 3'h7 : 3'(i % 5), (i < 10) ? 2'h0 : 2'(i / 10 + 1),
           1'(i / 5 % 2), 1'b0);
    end
  endtask
  // second byte queued while the first is shifting must follow with no gap
  task automatic t_back;
    logic [7:0] s;
    int t;
    fb = 4'h9;
    wreg(3'h3, 8'h06);
    wreg(3'h2, 8'h08);
    wreg(3'h1, 8'h40);
    wreg(3'h0, 8'h3c);
    s = 8'h00;
    for (t = 0; t < 40 && !s[5]; t++) rreg(3'h1, s);
    wreg(3'h0, 8'hc3);
    rreg(3'h1, s);
    chk("status busy", 13'h0, {11'h0, s[6:5]});
    t = frames;
    wait_frame(t + 1);
    chk("frame a", 13'h13c, rx_frame);
    wait_frame(t + 2);
    chk("frame b", 13'h1c3, rx_frame);
    repeat (20) @(posedge clk);
    rreg(3'h1, s);
    chk("status done", 13'h60, {5'h0, s});
    chk("idle", 13'h3, {11'h0, serial_out_oe, serial_out_pin});
  endtask
  task automatic t_rates;
    send(9'h05a, 3'h3, 2'h0, 1'b0, 1'b1);
    repeat (20) @(posedge clk);
    chk("released", 13'h1, {11'h0, serial_out_oe, serial_out_pin});
    u2x = 1'b1;
    bc = 8'h18;
    wreg(3'h4, 8'h02);
    send(9'h0c5, 3'h3, 2'h2, 1'b0, 1'b0);
    u2x = 1'b0;
    msel = 1'b1;
    @(posedge clk);
    xck_dir_master <= 1'b1;
    bc = 8'h08;
    wreg(3'h4, 8'h03);
    send(9'h13a, 3'h7, 2'h3, 1'b1, 1'b0);
    chk("xck_oe", 13'h1, {12'h0, xck_oe});
    // slave: the far end drives the transfer clock, data move on its falling edge
    @(posedge clk);
    xck_dir_master <= 1'b0;
    xck_run <= 1'b1;
    cpol = 1'b1;
    send(9'h0a5, 3'h2, 2'h2, 1'b0, 1'b0);
    chk("xck_oe slave", 13'h0, {12'h0, xck_oe});
  endtask
  task automatic final_report;
    if (errors == 0 && comparisons > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  // main sequence
  initial begin
    {clk, rst_b, wr, rd, xck_dir_master, msel, u2x, cpol, xck_run} = 9'h000;
    {addr, wdata, fb, bc} = {3'h0, 8'h00, 4'h9, 8'h10};
    errors = 0;
    comparisons = 0;
    repeat (8) @(posedge clk);
    rst_b <= 1'b1;
    t_reset;
    t_formats;
    t_back;
    t_rates;
    final_report;
  end
  // about 7000 cycles expected
  initial begin
    repeat (40000) @(posedge clk);
    errors++;
    final_report;
  end
endmodule
